//--- rtl/adc_mode_ctrl.sv
// Summary of operation
// - Reset bit write clears all mode registers
// - Software reset briefly forces full sleep
// - Reset bit self-clears when command ends
// - Reset register reads back random data
// - Power field selects normal, nap, sleep
// - Timing bit three inverts forwarded clock
// - Timing bits two-one delay forwarded clock
// - Timing bit zero enables duty stabilizer
// - Bits six-four select driver current
// - Termination bit enables termination, doubles current
// - Unused register bits are ignored
// - Frame: flag, seven-bit address, eight data
// - Read shifts register out, no update
// - Format 10 DDR single-ended, 11 unused
`timescale 1ns/100ps
module adc_mode_ctrl (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	// Serial configuration pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe,
	// Mode controls
	output adc_mode_pkg::mode_ctrl_t mode,
	output logic soft_reset_active
);
	import adc_mode_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SLEEP = 2'b01
	} reset_state_t;

	// ********************************
	// Serial front end
	// ********************************
	logic [15:0] rx_bits;
	logic header_valid;
	logic word_valid;
	logic frame_end;
	logic [7:0] read_data;

	serial_link_rx i_serial_link_rx (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.cs_n(cs_n),
		.sck(sck),
		.sdi(sdi),
		.sdo_o(sdo_o),
		.sdo_oe(sdo_oe),
		.read_data(read_data),
		.rx_bits(rx_bits),
		.header_valid(header_valid),
		.word_valid(word_valid),
		.frame_end(frame_end)
	);

	// ********************************
	// Register file
	// ********************************
	logic [1:0] power_down_ctrl;
	logic [3:0] output_timing_ctrl;
	logic [6:0] output_driver_ctrl;
	logic [7:0] lfsr;
	reset_state_t state;
	reset_state_t next_state;
	logic [7:0] sleep_cnt;

	wire [6:0] wr_addr = rx_bits[14:8];
	wire [7:0] wr_data = rx_bits[7:0];
	wire [6:0] rd_addr = rx_bits[6:0];
	wire commit = word_valid & ~rx_bits[15];
	wire wr_reset = commit & (wr_addr == ADDR_SOFT_RESET)
		& wr_data[SOFT_RESET_BIT];
	wire wr_pd = commit & (wr_addr == ADDR_POWER_DOWN);
	wire wr_tim = commit & (wr_addr == ADDR_TIMING);
	wire wr_drv = commit & (wr_addr == ADDR_DRIVER);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			power_down_ctrl <= PD_RESET;
			output_timing_ctrl <= TIMING_RESET;
			output_driver_ctrl <= DRIVER_RESET;
		end else if (clk_en) begin
			if (wr_reset) begin
				power_down_ctrl <= PD_RESET;
				output_timing_ctrl <= TIMING_RESET;
				output_driver_ctrl <= DRIVER_RESET;
			end else begin
				// Only whole committed words land here
				if (wr_pd) begin
					power_down_ctrl <= wr_data[PD_LSB +: 2];
				end
				if (wr_tim) begin
					output_timing_ctrl <= wr_data[3:0];
				end
				if (wr_drv) begin
					output_driver_ctrl <= wr_data[6:0];
				end
			end
		end
	end

	// Free-running scrambler for reset register reads
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lfsr <= LFSR_SEED;
		end else if (clk_en) begin
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		end
	end

	// ********************************
	// Read-back selection
	// ********************************
	wire [7:0] rd_pd = {6'h00, power_down_ctrl};
	wire [7:0] rd_tim = {4'h0, output_timing_ctrl};
	wire [7:0] rd_drv = {1'b0, output_driver_ctrl};
	assign read_data =
		(rd_addr == ADDR_SOFT_RESET) ? lfsr :
		(rd_addr == ADDR_POWER_DOWN) ? rd_pd :
		(rd_addr == ADDR_TIMING) ? rd_tim :
		(rd_addr == ADDR_DRIVER) ? rd_drv : 8'h00;

	// ********************************
	// Software reset sequence
	// ********************************
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (wr_reset) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (sleep_cnt == 8'h00) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			sleep_cnt <= 8'h00;
			soft_reset_active <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			if (wr_reset) begin
				sleep_cnt <= 8'(RESET_SLEEP_CYCLES - 1);
			end else if (sleep_cnt != 8'h00) begin
				sleep_cnt <= sleep_cnt - 8'h01;
			end
			if (wr_reset) begin
				soft_reset_active <= 1'b1;
			end else if (frame_end) begin
				soft_reset_active <= 1'b0;
			end
		end
	end

	// ********************************
	// Mode decode
	// ********************************
	wire force_sleep = (state == ST_SLEEP) | wr_reset;
	wire [1:0] pd_sel = power_down_ctrl;
	wire [2:0] cur_sel = output_driver_ctrl[DRV_CURRENT_LSB +: 3];
	wire term_on = output_driver_ctrl[DRV_TERM_BIT];
	wire [7:0] base_cur = current_lut(cur_sel);
	mode_ctrl_t next_mode;

	always_comb begin
		next_mode.power.sleep = force_sleep | (pd_sel == PD_SLEEP);
		next_mode.power.ch1_nap = ~next_mode.power.sleep
			& (pd_sel == PD_NAP_BOTH);
		next_mode.power.ch2_nap = ~next_mode.power.sleep
			& ((pd_sel == PD_NAP_CH2) | (pd_sel == PD_NAP_BOTH));
		next_mode.fwd_clock_invert =
			output_timing_ctrl[TIM_INVERT_BIT];
		next_mode.fwd_clock_delay_sel =
			output_timing_ctrl[TIM_DELAY_LSB +: 2];
		next_mode.duty_stabilizer_en =
			output_timing_ctrl[TIM_STAB_BIT];
		next_mode.diff_driver_current_sel = cur_sel;
		next_mode.internal_termination_en = term_on;
		next_mode.drive_current = term_on ?
			{base_cur[6:0], 1'b0} : base_cur;
		next_mode.data_out_oe =
			~output_driver_ctrl[DRV_DISABLE_BIT];
		next_mode.output_format_select = out_format_t'(
			output_driver_ctrl[DRV_FORMAT_LSB +: 2]);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mode <= '0;
		end else if (clk_en) begin
			mode <= next_mode;
		end
	end

	// ********************************
	// Checks
	// ********************************
	property p_reset_clears;
		@(posedge clk_sys) disable iff (!arst_n)
		(clk_en && wr_reset) |=> (power_down_ctrl == 2'h0)
			&& (output_timing_ctrl == 4'h0)
			&& (output_driver_ctrl == 7'h00);
	endproperty
	a_reset_clears: assert property (p_reset_clears)
		else $error("software reset left a register set");

	property p_reset_sleep;
		@(posedge clk_sys) disable iff (!arst_n)
		(clk_en && wr_reset) |=> mode.power.sleep
			&& state == ST_SLEEP;
	endproperty
	a_reset_sleep: assert property (p_reset_sleep)
		else $error("software reset did not force sleep");

	property p_self_clear;
		@(posedge clk_sys) disable iff (!arst_n)
		(clk_en && frame_end && !wr_reset) |=> !soft_reset_active;
	endproperty
	a_self_clear: assert property (p_self_clear)
		else $error("reset bit stayed set after command end");

	property p_read_no_write;
		@(posedge clk_sys) disable iff (!arst_n)
		(clk_en && word_valid && rx_bits[15]) |=>
			$stable(power_down_ctrl) && $stable(output_timing_ctrl)
			&& $stable(output_driver_ctrl);
	endproperty
	a_read_no_write: assert property (p_read_no_write)
		else $error("read command changed a register");

	property p_no_partial;
		@(posedge clk_sys) disable iff (!arst_n)
		!word_valid |=> $stable(output_driver_ctrl)
			&& $stable(output_timing_ctrl);
	endproperty
	a_no_partial: assert property (p_no_partial)
		else $error("register changed without a whole word");

	property p_pd_sleep;
		@(posedge clk_sys) disable iff (!arst_n)
		(clk_en && power_down_ctrl == 2'b11) |=>
			mode.power.sleep && !mode.power.ch2_nap;
	endproperty
	a_pd_sleep: assert property (p_pd_sleep)
		else $error("power code 11 did not give sleep");

	property p_term_double;
		@(posedge clk_sys) disable iff (!arst_n)
		(clk_en && term_on && !wr_reset) |=>
			mode.drive_current == 8'($past(base_cur) * 2);
	endproperty
	a_term_double: assert property (p_term_double)
		else $error("termination did not double current");

	property p_out_disable;
		@(posedge clk_sys) disable iff (!arst_n)
		(clk_en && wr_drv && wr_data[DRV_DISABLE_BIT]) |=>
			##1 !mode.data_out_oe;
	endproperty
	a_out_disable: assert property (p_out_disable)
		else $error("outputs still enabled after disable");

	property p_invert;
		@(posedge clk_sys) disable iff (!arst_n)
		clk_en |=> mode.fwd_clock_invert
			== $past(output_timing_ctrl[TIM_INVERT_BIT]);
	endproperty
	a_invert: assert property (p_invert)
		else $error("clock invert does not follow timing bit");

endmodule

//--- rtl/adc_mode_pkg.sv
package adc_mode_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
	localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
	localparam logic [6:0] ADDR_TIMING = 7'h02;
	localparam logic [6:0] ADDR_DRIVER = 7'h03;

	localparam int SOFT_RESET_BIT = 7;
	localparam int PD_LSB = 0;
	localparam int TIM_STAB_BIT = 0;
	localparam int TIM_DELAY_LSB = 1;
	localparam int TIM_INVERT_BIT = 3;
	localparam int DRV_FORMAT_LSB = 0;
	localparam int DRV_DISABLE_BIT = 2;
	localparam int DRV_TERM_BIT = 3;
	localparam int DRV_CURRENT_LSB = 4;

	localparam logic [1:0] PD_RESET = 2'h0;
	localparam logic [3:0] TIMING_RESET = 4'h0;
	localparam logic [6:0] DRIVER_RESET = 7'h00;
	localparam logic [7:0] LFSR_SEED = 8'h01;

	// ********************************
	// Serial frame and timing
	// ********************************
	localparam int FRAME_BITS = 16;
	localparam int HEADER_BITS = 8;
	localparam int CLK_SYS_MHZ = 125;
	localparam int RESET_SLEEP_NS = 800;
	localparam int RESET_SLEEP_CYCLES =
		(RESET_SLEEP_NS * CLK_SYS_MHZ + 999) / 1000;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [1:0] {
		PD_NORMAL = 2'b00,
		PD_NAP_CH2 = 2'b01,
		PD_NAP_BOTH = 2'b10,
		PD_SLEEP = 2'b11
	} power_mode_t;

	typedef enum logic [1:0] {
		FMT_FULL_SE = 2'b00,
		FMT_DDR_DIFF = 2'b01,
		FMT_DDR_SE = 2'b10,
		FMT_UNUSED = 2'b11
	} out_format_t;

	typedef struct packed {
		logic ch1_nap;
		logic ch2_nap;
		logic sleep;
	} power_state_t;

	typedef struct packed {
		power_state_t power;
		logic fwd_clock_invert;
		logic [1:0] fwd_clock_delay_sel;
		logic duty_stabilizer_en;
		logic [2:0] diff_driver_current_sel;
		logic internal_termination_en;
		logic [7:0] drive_current;
		logic data_out_oe;
		out_format_t output_format_select;
	} mode_ctrl_t;

	// Driver current in units of 0.05 mA
	function automatic logic [7:0] current_lut(input logic [2:0] sel);
		case (sel)
			3'h0: current_lut = 8'h46;
			3'h1: current_lut = 8'h50;
			3'h2: current_lut = 8'h5A;
			3'h4: current_lut = 8'h3C;
			3'h5: current_lut = 8'h32;
			3'h6: current_lut = 8'h2A;
			3'h7: current_lut = 8'h23;
			default: current_lut = 8'h00;
		endcase
	endfunction

endpackage

//--- rtl/serial_link_rx.sv
`timescale 1ns/100ps
module serial_link_rx (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	// Serial pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe,
	// Frame side
	input wire logic [7:0] read_data,
	output logic [15:0] rx_bits,
	output logic header_valid,
	output logic word_valid,
	output logic frame_end
);
	import adc_mode_pkg::*;

	// ********************************
	// Pin synchronisers and edges
	// ********************************
	logic [1:0] cs_sync;
	logic [1:0] sck_sync;
	logic [1:0] sdi_sync;
	logic sck_prev;
	logic cs_prev;
	logic [4:0] bit_cnt;
	logic [7:0] rd_shift;
	logic rd_active;
	logic sdo_bit;
	logic sdo_en;

	wire cs_low = ~cs_sync[1];
	wire sck_rise = sck_sync[1] & ~sck_prev;
	wire sck_fall = ~sck_sync[1] & sck_prev;
	wire take_bit = cs_low & sck_rise & (bit_cnt < 5'(FRAME_BITS));
	wire at_header = take_bit & (bit_cnt == 5'(HEADER_BITS - 1));
	wire at_last = take_bit & (bit_cnt == 5'(FRAME_BITS - 1));

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cs_sync <= 2'h3;
			sck_sync <= 2'h0;
			sdi_sync <= 2'h0;
			sck_prev <= 1'b0;
			cs_prev <= 1'b1;
		end else if (clk_en) begin
			cs_sync <= {cs_sync[0], cs_n};
			sck_sync <= {sck_sync[0], sck};
			sdi_sync <= {sdi_sync[0], sdi};
			sck_prev <= sck_sync[1];
			cs_prev <= cs_sync[1];
		end
	end

	// ********************************
	// Frame shifter
	// ********************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt <= 5'h00;
			rx_bits <= 16'h0000;
			header_valid <= 1'b0;
			word_valid <= 1'b0;
			frame_end <= 1'b0;
		end else if (clk_en) begin
			header_valid <= at_header;
			word_valid <= at_last;
			frame_end <= cs_sync[1] & ~cs_prev;
			if (!cs_low) begin
				bit_cnt <= 5'h00;
			end else if (take_bit) begin
				rx_bits <= {rx_bits[14:0], sdi_sync[1]};
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// ********************************
	// Read-back driver
	// ********************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_shift <= 8'h00;
			rd_active <= 1'b0;
			sdo_bit <= 1'b1;
			sdo_en <= 1'b0;
		end else if (clk_en) begin
			if (!cs_low) begin
				rd_active <= 1'b0;
				sdo_en <= 1'b0;
			end else if (header_valid && rx_bits[7]) begin
				rd_shift <= read_data;
				rd_active <= 1'b1;
			end else if (sck_fall && rd_active) begin
				sdo_en <= (bit_cnt < 5'(FRAME_BITS));
				sdo_bit <= rd_shift[7];
				rd_shift <= {rd_shift[6:0], 1'b0};
			end
		end
	end

	// Open drain: only ever pulls low
	assign sdo_o = 1'b0;
	assign sdo_oe = sdo_en & ~sdo_bit;

	property p_frame_len;
		@(posedge clk_sys) disable iff (!arst_n)
		bit_cnt <= 5'(FRAME_BITS);
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("bit counter ran past the frame");

	property p_sdo_release;
		@(posedge clk_sys) disable iff (!arst_n)
		(clk_en && !cs_low) |=> !sdo_oe;
	endproperty
	a_sdo_release: assert property (p_sdo_release)
		else $error("data-out held low outside a frame");

endmodule

//--- verif/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
	// Clock
	input wire logic clk_sys,
	// Serial pins
	output logic cs_n,
	output logic sck,
	output logic sdi,
	input wire logic sdo_line
);
	// ****************************************
	// Idle pins
	// ****************************************
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// ****************************************
	// One frame, MSB first, nbits rises
	// ****************************************
	task automatic xfer(input logic [15:0] w, input int nbits,
		output logic [7:0] rd);
		rd = 8'h00;
		tick(1);
		cs_n = 1'b0;
		tick(10);
		for (int i = 15; i > 15 - nbits; i--) begin
			sdi = w[i];
			tick(10);
			if (i < 8)
				rd = {rd[6:0], sdo_line};
			sck = 1'b1;
			tick(10);
			sck = 1'b0;
		end
		tick(10);
		cs_n = 1'b1;
		// Released data line must not keep its last level
		sdi = ~sdi;
		tick(10);
	endtask
endmodule

//--- verif/adc_mode_ctrl_bench.sv
`timescale 1ns/100ps
module adc_mode_ctrl_bench;
	import adc_mode_pkg::*;
	localparam logic [7:0] CUR [8] = '{8'h46, 8'h50, 8'h5A, 8'h00,
		8'h3C, 8'h32, 8'h2A, 8'h23};
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic cs_n, sck, sdi, sdo_o, sdo_oe, sra;
	logic sdo_line;
	mode_ctrl_t mode;
	logic [7:0] rd;
	logic saw_sleep = 1'b0;
	logic saw_sra = 1'b0;
	logic saw_clr = 1'b0;
	int fail_count = 0;
	int check_count = 0;

	always #4 clk_sys = ~clk_sys;
	// Open drain with pull-up
	assign sdo_line = sdo_oe ? sdo_o : 1'b1;

	adc_mode_ctrl i_adc_mode_ctrl (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.cs_n(cs_n),
		.sck(sck),
		.sdi(sdi),
		.sdo_o(sdo_o),
		.sdo_oe(sdo_oe),
		.mode(mode),
		.soft_reset_active(sra)
	);

	spi_host_model i_spi_host_model (
		.clk_sys(clk_sys),
		.cs_n(cs_n),
		.sck(sck),
		.sdi(sdi),
		.sdo_line(sdo_line)
	);

	// Sticky watchers, cleared on request
	always @(posedge clk_sys) begin
		if (saw_clr) begin
			saw_sleep <= 1'b0;
			saw_sra <= 1'b0;
		end else begin
			if (mode.power.sleep === 1'b1)
				saw_sleep <= 1'b1;
			if (sra === 1'b1)
				saw_sra <= 1'b1;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic mode_ctrl_t em(input logic [7:0] pd, tm, dr);
		mode_ctrl_t m;
		logic [7:0] c;
		c = CUR[dr[6:4]];
		m.power.sleep = (pd[1:0] == 2'h3);
		m.power.ch2_nap = (pd[1:0] == 2'h1) || (pd[1:0] == 2'h2);
		m.power.ch1_nap = (pd[1:0] == 2'h2);
		m.fwd_clock_invert = tm[3];
		m.fwd_clock_delay_sel = tm[2:1];
		m.duty_stabilizer_en = tm[0];
		m.diff_driver_current_sel = dr[6:4];
		m.internal_termination_en = dr[3];
		m.drive_current = dr[3] ? {c[6:0], 1'b0} : c;
		m.data_out_oe = ~dr[2];
		m.output_format_select = out_format_t'(dr[1:0]);
		return m;
	endfunction

	task automatic cm(input logic [7:0] pd, tm, dr);
		chk("mode", 32'(mode), 32'(em(pd, tm, dr)));
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_spi_host_model.xfer({1'b0, a, d}, 16, rd);
	endtask

	task automatic rc(input logic [6:0] a, input logic [7:0] exp);
		i_spi_host_model.xfer({1'b1, a, 8'hA5}, 16, rd);
		chk("read", 32'(rd), 32'(exp));
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_soft_reset;
		cm(8'h0, 8'h0, 8'h0);
		chk("sdo_oe", 32'(sdo_oe), 32'h0);
		wr(ADDR_SOFT_RESET, 8'h80);
		chk("sleep", 32'(mode.power.sleep), 32'h1);
		chk("reset seen", 32'(saw_sra), 32'h1);
		chk("reset bit", 32'(sra), 32'h0);
		tick(100);
		cm(8'h0, 8'h0, 8'h0);
		wr(ADDR_POWER_DOWN, 8'h03);
		wr(ADDR_TIMING, 8'h0F);
		wr(ADDR_DRIVER, 8'h7F);
		wr(ADDR_SOFT_RESET, 8'h7F);
		cm(8'h3, 8'h0F, 8'h7F);
		wr(ADDR_SOFT_RESET, 8'h80);
		tick(100);
		cm(8'h0, 8'h0, 8'h0);
		rc(ADDR_DRIVER, 8'h00);
		rc(ADDR_TIMING, 8'h00);
		$display("test soft reset done");
	endtask

	task automatic t_power;
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_POWER_DOWN, {6'h3F, c[1:0]});
			cm(8'(c), 8'h0, 8'h0);
			rc(ADDR_POWER_DOWN, 8'(c));
		end
		wr(ADDR_POWER_DOWN, 8'h00);
		$display("test power done");
	endtask

	task automatic t_timing;
		for (int i = 0; i < 16; i++) begin
			if (i[2:1] != 2'h0 && !i[0])
				continue;
			wr(ADDR_TIMING, {4'hF, i[3:0]});
			cm(8'h0, 8'(i), 8'h0);
			rc(ADDR_TIMING, 8'(i));
		end
		$display("test timing done");
	endtask

	task automatic t_driver;
		logic [7:0] d;
		wr(ADDR_POWER_DOWN, 8'h03);
		wr(ADDR_TIMING, 8'h00);
		for (int i = 0; i < 16; i++) begin
			d = {1'b1, i[2:0], i[3], i[1], i[1:0]};
			wr(ADDR_DRIVER, d);
			cm(8'h3, 8'h0, d);
			rc(ADDR_DRIVER, d & 8'h7F);
		end
		wr(ADDR_DRIVER, 8'h00);
		wr(ADDR_POWER_DOWN, 8'h00);
		$display("test driver done");
	endtask

	task automatic t_read;
		wr(ADDR_TIMING, 8'h07);
		saw_clr = 1'b1;
		tick(1);
		saw_clr = 1'b0;
		i_spi_host_model.xfer({1'b1, ADDR_SOFT_RESET, 8'h80}, 16, rd);
		chk("reset seen", 32'(saw_sra), 32'h0);
		chk("sleep seen", 32'(saw_sleep), 32'h0);
		cm(8'h0, 8'h07, 8'h0);
		rc(7'h7F, 8'h00);
		$display("test read done");
	endtask

	task automatic t_partial;
		wr(ADDR_TIMING, 8'h01);
		i_spi_host_model.xfer({1'b0, ADDR_TIMING, 8'h0E}, 15, rd);
		cm(8'h0, 8'h01, 8'h0);
		i_spi_host_model.xfer({1'b0, ADDR_POWER_DOWN, 8'h03}, 9, rd);
		cm(8'h0, 8'h01, 8'h0);
		$display("test partial done");
	endtask

	task automatic t_freeze;
		clk_en = 1'b0;
		wr(ADDR_POWER_DOWN, 8'h03);
		cm(8'h0, 8'h01, 8'h0);
		clk_en = 1'b1;
		tick(4);
		cm(8'h0, 8'h01, 8'h0);
		wr(ADDR_POWER_DOWN, 8'h03);
		cm(8'h3, 8'h01, 8'h0);
		arst_n = 1'b0;
		tick(2);
		chk("reset mode", 32'(mode), 32'h0);
		arst_n = 1'b1;
		tick(2);
		cm(8'h0, 8'h0, 8'h0);
		rc(ADDR_POWER_DOWN, 8'h00);
		$display("test freeze done");
	endtask

	// ****************************************
	// Run control
	// ****************************************
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		conclude();
	end

	initial begin
		tick(20);
		arst_n = 1'b1;
		tick(2);
		t_soft_reset();
		t_power();
		t_timing();
		t_driver();
		t_read();
		t_partial();
		t_freeze();
		conclude();
	end
endmodule
